// >>> rtl/lbus_pins.sv
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "lbus_defines.svh"
// Overview of operation
// RQ1: NMI rising edge latched, synchronised, type 2 started at instruction boundary.
// RQ2: source holds NMI high at least one clock-output period.
// RQ3: maskable request inputs are active high and pass a synchroniser.
// RQ4: third and fourth request pins can become active-low acknowledge outputs.
// RQ5: each maskable input is edge or level triggered, chosen per input.
// RQ6: sources keep requests asserted until acknowledged.
// RQ7: upper four address bits driven high-true during T1.
// RQ8: top status line low for processor cycles, high for DMA or refresh.
// RQ9: other three status lines low during T2, T3, wait and T4.
// RQ10: address, status and address/data lines float during hold or reset.
// RQ11: middle address lines carry a valid address from T1 to T4.
// RQ12: low lines carry address in T1 and data in T2 to T4.
// RQ13: refresh indicator high in compatible mode, low per refresh in enhanced.
// RQ14: refresh indicator floats during hold or reset in both modes.
// RQ15: address strobe pulses high; address valid at its falling edge.
// RQ16: write strobe low marks a write; it floats during hold or reset.
// RQ17: in queue status mode strobe pins carry two queue status bits.
// RQ18: queue codes: 00 none, 01 first byte, 11 next byte, 10 emptied.
// RQ19: read strobe pin sampled after reset; low selects queue status mode.
// RQ20: enhanced mode if test high at release and low four periods later.
// RQ21: cycle runs T1, T2, T3, waits, T4, one clock-output period each.
module lbus_pins import lbus_pkg::*; #(parameter int unsigned CLOCK_OUTPUT_DIV = 2) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// avalon-mm slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// core side
	input wire logic i_instr_boundary,
	input wire logic i_bus_hold,
	output logic o_nmi_start,
	output logic [7:0] o_int_type,
	// interrupt pins
	input wire logic i_nmi_pin,
	input wire logic i_irq_in_a,
	input wire logic i_irq_in_b_or_slave_sel,
	input wire logic i_irq_in_c_or_ack_out_a,
	output logic o_irq_in_c_or_ack_out_a,
	output logic o_irq_in_c_or_ack_out_a_oe,
	input wire logic i_irq_in_d_or_ack_out_b,
	output logic o_irq_in_d_or_ack_out_b,
	output logic o_irq_in_d_or_ack_out_b_oe,
	// mode straps
	input wire logic i_test_pin,
	input wire logic i_read_strobe_or_queue_mode_sel,
	// local bus pins
	output logic o_clock_output,
	output logic [3:0] o_upper_addr_status,
	output logic o_upper_addr_status_oe,
	output logic [7:0] o_mid_addr_line,
	output logic o_mid_addr_line_oe,
	input wire logic [7:0] i_muxed_addr_data_line,
	output logic [7:0] o_muxed_addr_data_line,
	output logic o_muxed_addr_data_line_oe,
	output logic o_refresh_cycle_n,
	output logic o_refresh_cycle_n_oe,
	output logic o_addr_strobe_or_queue_stat0,
	output logic o_write_strobe_or_queue_stat1,
	output logic o_write_strobe_or_queue_stat1_oe
);
	localparam int STRAP_CYC = `STRAP_CLKOUTS * CLOCK_OUTPUT_DIV;
	localparam int ACK_CYC = `ACK_CLKOUTS * CLOCK_OUTPUT_DIV;
	localparam int QS_CYC = `QS_CLKOUTS * CLOCK_OUTPUT_DIV;

	typedef struct packed {
		logic wreq;
		logic [31:0] rdata;
		logic [`CTRL_HI:0] ctrl;
		logic [19:0] addr;
		logic [7:0] wdata;
		logic [7:0] rd_data;
		logic [19:0] cyc_addr;
		logic [7:0] cmd;
		logic go;
		logic busy;
		logic [1:0] qs;
		logic [7:0] qs_cnt;
		logic [3:0] irq_prev;
		logic [3:0] irq_pend;
		logic [1:0] ack_mask;
		logic [7:0] ack_cnt;
		logic nmi_prev;
		logic nmi_latched;
		logic nmi_start;
		logic [7:0] int_type;
		logic [7:0] strap_cnt;
		logic test_first;
		logic enhanced;
		logic queue_mode;
		logic mode_done;
		logic clock_output;
		logic [3:0] upper;
		logic upper_oe;
		logic [7:0] mid;
		logic mid_oe;
		logic [7:0] ad;
		logic ad_oe;
		logic refresh_cycle_n_n;
		logic refresh_cycle_n_oe;
		logic strobe0;
		logic strobe1;
		logic strobe1_oe;
		logic ackc;
		logic ackc_oe;
		logic ackd;
		logic ackd_oe;
	} pins_t;

	pins_t st_reg, st_next;
	logic [`SY_W-1:0] sy;

	bus_seq_if sq();

	// every pin from outside the clock domain passes the same filter
	pin_sync3 #(.W(`SY_W)) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_nmi_pin, i_test_pin, i_read_strobe_or_queue_mode_sel,
			i_irq_in_d_or_ack_out_b, i_irq_in_c_or_ack_out_a,
			i_irq_in_b_or_slave_sel, i_irq_in_a}),
		.o_level(sy)
	);

	bus_tstate_seq #(.CLOCK_OUTPUT_DIV(CLOCK_OUTPUT_DIV)) u_seq (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.sq(sq.seq)
	);

	// the sequencer follows the go flag and the wait count of the latched command
	assign sq.go = st_reg.go;
	assign sq.waits = st_reg.cmd[`CMD_WS_HI:`CMD_WS_LO];

	always_comb begin
		logic req;
		logic [3:0] irq_in;
		logic [3:0] ack_clr;
		logic nmi_take;
		logic in_cyc;
		logic data_ph;
		logic is_wr;
		logic hold;
		req = (i_avs_read | i_avs_write) & st_reg.wreq;
		irq_in = '0;
		ack_clr = '0;
		nmi_take = 1'b0;
		in_cyc = (sq.tstate != T_IDLE);
		data_ph = in_cyc && (sq.tstate != T_1);
		is_wr = st_reg.cmd[`CMD_WR];
		hold = i_bus_hold;
		st_next = st_reg;

		// queue code shows for one clock-output period; counted first so a new code wins
		if (st_reg.qs_cnt != 8'h00) begin
			st_next.qs_cnt = st_reg.qs_cnt - 8'h01;
			if (st_reg.qs_cnt == 8'h01) st_next.qs = `QS_NOP; // [RQ18]
		end

		// bus slave: answer one cycle after the request, then rearm
		st_next.wreq = 1'b1;
		if (req) begin
			st_next.wreq = 1'b0;
			if (i_avs_read) begin
				unique case (i_avs_address)
					`OFS_CTRL: st_next.rdata = 32'(st_reg.ctrl);
					`OFS_ADDR: st_next.rdata = 32'(st_reg.addr);
					`OFS_DATA: st_next.rdata = 32'(st_reg.rd_data);
					`OFS_CMD: st_next.rdata = 32'(st_reg.cmd);
					`OFS_STAT: st_next.rdata = 32'({st_reg.mode_done, st_reg.irq_pend,
						st_reg.nmi_latched, st_reg.queue_mode, st_reg.enhanced,
						st_reg.busy});
					`OFS_QSTAT: st_next.rdata = 32'(st_reg.qs);
					default: st_next.rdata = 32'h0000_0000;
				endcase
			end else begin
				st_next.rdata = 32'h0000_0000;
				unique case (i_avs_address)
					`OFS_CTRL: st_next.ctrl = i_avs_writedata[`CTRL_HI:0];
					`OFS_ADDR: st_next.addr = i_avs_writedata[19:0];
					`OFS_DATA: st_next.wdata = i_avs_writedata[7:0];
					`OFS_CMD: begin
						// refused while a cycle runs, while held, or before straps settle
						if (!st_reg.busy && st_reg.mode_done && !hold) begin
							st_next.cmd = i_avs_writedata[7:0];
							st_next.cyc_addr = st_reg.addr;
							st_next.go = 1'b1;
							st_next.busy = 1'b1;
						end
					end
					`OFS_QSTAT: begin
						st_next.qs = i_avs_writedata[1:0]; // [RQ18]
						st_next.qs_cnt = 8'(QS_CYC);
					end
					`OFS_ACK: ack_clr = i_avs_writedata[3:0];
					default: ;
				endcase
			end
		end

		// bus cycle bookkeeping
		if (sq.tstate == T_1) st_next.go = 1'b0;
		if (sq.tstate == T_4 && sq.period_end && !st_reg.go) st_next.busy = 1'b0;
		if ((sq.tstate == T_3 || sq.tstate == T_W) && sq.period_end && !is_wr) begin
			// the last capture before T4 is the one that stands
			st_next.rd_data = i_muxed_addr_data_line; // [RQ12]
		end

		// straps: sample once the filter has filled, then four periods later
		if (!st_reg.mode_done) begin
			st_next.strap_cnt = st_reg.strap_cnt + 8'h01;
			if (st_reg.strap_cnt == `STRAP_SETTLE) begin
				st_next.test_first = sy[`SY_TEST]; // [RQ20]
				st_next.queue_mode = !sy[`SY_RDS]; // [RQ19]
			end
			if (st_reg.strap_cnt == `STRAP_SETTLE + 8'(STRAP_CYC)) begin
				st_next.enhanced = st_reg.test_first && !sy[`SY_TEST]; // [RQ20]
				st_next.mode_done = 1'b1;
			end
		end

		// maskable requests; pins configured as acknowledges read as idle
		irq_in = sy[`SY_IRQ_HI:0]; // [RQ3]
		irq_in[2] = irq_in[2] & !st_reg.ctrl[`CTRL_ACKC]; // [RQ4]
		irq_in[3] = irq_in[3] & !st_reg.ctrl[`CTRL_ACKD]; // [RQ4]
		st_next.irq_prev = irq_in;
		for (int i = 0; i <= `CTRL_LVL_HI; i++) begin
			if (st_reg.ctrl[i]) begin
				// level mode: pending follows the pin
				st_next.irq_pend[i] = irq_in[i]; // [RQ5]
			end else begin
				// edge mode: a new edge beats a clear in the same cycle
				st_next.irq_pend[i] = (irq_in[i] & !st_reg.irq_prev[i]) |
					(st_reg.irq_pend[i] & !ack_clr[i]); // [RQ5]
			end
		end

		// acknowledge pulses, low for one clock-output period
		if (ack_clr[3:2] != 2'h0) begin
			st_next.ack_mask = ack_clr[3:2] & {st_reg.ctrl[`CTRL_ACKD], st_reg.ctrl[`CTRL_ACKC]};
			st_next.ack_cnt = 8'(ACK_CYC);
		end else if (st_reg.ack_cnt != 8'h00) begin
			st_next.ack_cnt = st_reg.ack_cnt - 8'h01;
		end else begin
			st_next.ack_mask = 2'h0;
		end
		st_next.ackc = !(st_reg.ack_mask[0] && st_reg.ack_cnt != 8'h00); // [RQ4]
		st_next.ackc_oe = st_reg.ctrl[`CTRL_ACKC]; // [RQ4]
		st_next.ackd = !(st_reg.ack_mask[1] && st_reg.ack_cnt != 8'h00); // [RQ4]
		st_next.ackd_oe = st_reg.ctrl[`CTRL_ACKD]; // [RQ4]

		// nmi: latch the filtered rise, start at the next boundary
		st_next.nmi_prev = sy[`SY_NMI];
		nmi_take = st_reg.nmi_latched && i_instr_boundary; // [RQ1]
		st_next.nmi_latched = (sy[`SY_NMI] && !st_reg.nmi_prev) ||
			(st_reg.nmi_latched && !nmi_take); // [RQ1]
		st_next.nmi_start = nmi_take;
		if (nmi_take) st_next.int_type = `NMI_TYPE; // [RQ1]

		// pin values; every pin lags the state by one clock so all stay aligned
		st_next.clock_output = sq.clock_output;
		st_next.upper = (sq.tstate == T_1) ? st_reg.cyc_addr[19:16] : // [RQ7]
			{in_cyc && (st_reg.cmd[`CMD_DMA] || st_reg.cmd[`CMD_REFRESH_CYCLE_N]), 3'h0}; // [RQ8] [RQ9]
		st_next.upper_oe = !hold; // [RQ10]
		st_next.mid = st_reg.cyc_addr[15:8]; // [RQ11]
		st_next.mid_oe = !hold; // [RQ10]
		st_next.ad = (sq.tstate == T_1) ? st_reg.cyc_addr[7:0] : st_reg.wdata; // [RQ12]
		// reads leave the low lines to the addressed device after T1
		st_next.ad_oe = !hold && ((sq.tstate == T_1) || (data_ph && is_wr)); // [RQ10] [RQ12]
		st_next.refresh_cycle_n_n = !(st_reg.enhanced && in_cyc && st_reg.cmd[`CMD_REFRESH_CYCLE_N]); // [RQ13]
		st_next.refresh_cycle_n_oe = !hold; // [RQ14]
		if (st_reg.queue_mode) begin
			st_next.strobe0 = st_reg.qs[0]; // [RQ17]
			st_next.strobe1 = st_reg.qs[1]; // [RQ17]
			st_next.strobe1_oe = 1'b1;
		end else begin
			// address is already stable when the first half of T1 ends
			st_next.strobe0 = (sq.tstate == T_1) && sq.clock_output; // [RQ15]
			st_next.strobe1 = !(is_wr && data_ph && sq.tstate != T_4); // [RQ16]
			st_next.strobe1_oe = !hold; // [RQ16]
		end
	end

	// reset floats the bus and sets every strobe inactive
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.wreq <= 1'b1;
			st_reg.refresh_cycle_n_n <= 1'b1;
			st_reg.strobe1 <= 1'b1;
			st_reg.ackc <= 1'b1;
			st_reg.ackd <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flip-flops
	assign o_avs_readdata = st_reg.rdata;
	assign o_avs_waitrequest = st_reg.wreq;
	assign o_nmi_start = st_reg.nmi_start;
	assign o_int_type = st_reg.int_type;
	assign o_irq_in_c_or_ack_out_a = st_reg.ackc;
	assign o_irq_in_c_or_ack_out_a_oe = st_reg.ackc_oe;
	assign o_irq_in_d_or_ack_out_b = st_reg.ackd;
	assign o_irq_in_d_or_ack_out_b_oe = st_reg.ackd_oe;
	assign o_clock_output = st_reg.clock_output;
	assign o_upper_addr_status = st_reg.upper;
	assign o_upper_addr_status_oe = st_reg.upper_oe;
	assign o_mid_addr_line = st_reg.mid;
	assign o_mid_addr_line_oe = st_reg.mid_oe;
	assign o_muxed_addr_data_line = st_reg.ad;
	assign o_muxed_addr_data_line_oe = st_reg.ad_oe;
	assign o_refresh_cycle_n = st_reg.refresh_cycle_n_n;
	assign o_refresh_cycle_n_oe = st_reg.refresh_cycle_n_oe;
	assign o_addr_strobe_or_queue_stat0 = st_reg.strobe0;
	assign o_write_strobe_or_queue_stat1 = st_reg.strobe1;
	assign o_write_strobe_or_queue_stat1_oe = st_reg.strobe1_oe;

	logic in_cyc_rd;
	assign in_cyc_rd = (sq.tstate != T_IDLE) && !st_reg.cmd[`CMD_WR];
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	chk_nmi_take: assert property ( // [RQ1]
		o_nmi_start |-> ($past(st_reg.nmi_latched) && $past(i_instr_boundary) && o_int_type == `NMI_TYPE))
		else $error("nmi start without latched edge and boundary");
	chk_upper_addr: assert property ( // [RQ7]
		(sq.tstate == T_1 && !i_bus_hold) |=> (o_upper_addr_status == st_reg.cyc_addr[19:16]))
		else $error("upper address missing in T1");
	chk_status_origin: assert property ( // [RQ8]
		(sq.tstate inside {T_2, T_3, T_W, T_4}) |=>
		(o_upper_addr_status[3] == (st_reg.cmd[`CMD_DMA] || st_reg.cmd[`CMD_REFRESH_CYCLE_N])))
		else $error("cycle origin status wrong");
	chk_status_zero: assert property ( // [RQ9]
		(sq.tstate inside {T_2, T_3, T_W, T_4}) |=> (o_upper_addr_status[2:0] == 3'h0))
		else $error("low status lines not low");
	chk_float_hold: assert property ( // [RQ10]
		i_bus_hold |=> !(o_upper_addr_status_oe || o_mid_addr_line_oe ||
		o_muxed_addr_data_line_oe || o_refresh_cycle_n_oe))
		else $error("bus driven during hold");
	chk_refresh_compat: assert property ( // [RQ13]
		(st_reg.mode_done && !st_reg.enhanced) |=> o_refresh_cycle_n)
		else $error("refresh low in compatible mode");
	chk_write_read: assert property ( // [RQ16]
		(!st_reg.queue_mode && in_cyc_rd) |=> o_write_strobe_or_queue_stat1)
		else $error("write strobe low in a read cycle");
	chk_queue_pins: assert property ( // [RQ17]
		st_reg.queue_mode |=> ({o_write_strobe_or_queue_stat1,
		o_addr_strobe_or_queue_stat0} == $past(st_reg.qs)))
		else $error("queue status not on strobe pins");
	chk_ack_pulse: assert property ( // [RQ4]
		($rose(st_reg.ack_mask[0]) && st_reg.ctrl[`CTRL_ACKC]) |-> ##1 !o_irq_in_c_or_ack_out_a)
		else $error("acknowledge pulse missing");
	chk_ale_t1: assert property ( // [RQ15]
		$fell(o_addr_strobe_or_queue_stat0) && !st_reg.queue_mode |-> o_mid_addr_line_oe ||
		$past(i_bus_hold))
		else $error("strobe fell without driven address");
endmodule
`default_nettype wire

// >>> rtl/lbus_defines.svh
`ifndef LBUS_DEFINES_SVH
`define LBUS_DEFINES_SVH
// register byte offsets
`define OFS_CTRL 5'h00
`define OFS_ADDR 5'h04
`define OFS_DATA 5'h08
`define OFS_CMD 5'h0c
`define OFS_STAT 5'h10
`define OFS_QSTAT 5'h14
`define OFS_ACK 5'h18
// control fields
`define CTRL_LVL_HI 3
`define CTRL_ACKC 4
`define CTRL_ACKD 5
`define CTRL_HI 5
// command fields
`define CMD_WR 0
`define CMD_DMA 1
`define CMD_REFRESH_CYCLE_N 2
`define CMD_WS_LO 4
`define CMD_WS_HI 7
// synchroniser lanes
`define SY_IRQ_HI 3
`define SY_RDS 4
`define SY_TEST 5
`define SY_NMI 6
`define SY_W 7
// constants and timing
`define NMI_TYPE 8'h02
`define QS_NOP 2'h0
`define STRAP_SETTLE 8'h04
`define STRAP_CLKOUTS 8'h04
`define ACK_CLKOUTS 8'h01
`define QS_CLKOUTS 8'h01
`endif

// >>> rtl/lbus_pkg.sv
package lbus_pkg;
	// bus states of one cycle, idle between cycles
	typedef enum logic [2:0] {T_IDLE, T_1, T_2, T_3, T_W, T_4} tstate_t;
	typedef struct packed {
		logic [7:0] div;
		logic [3:0] waits;
		tstate_t ts;
	} seq_t;
endpackage

// >>> rtl/bus_seq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bus_seq_if;
	import lbus_pkg::*;
	logic go;
	logic [3:0] waits;
	tstate_t tstate;
	logic clock_output;
	logic period_end;
	modport ctl(output go, waits, input tstate, clock_output, period_end);
	modport seq(input go, waits, output tstate, clock_output, period_end);
endinterface
`default_nettype wire

// >>> rtl/pin_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(parameter int unsigned W = 1) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// raw pins and filtered levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;
	sync_t st_reg, st_next;
	// s1 feeds only s2; the level moves once s2 and s3 agree
	always_comb begin
		st_next.s1 = i_async;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 ^ st_reg.s3)); // [RQ3]
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) st_reg <= '0;
		else st_reg <= st_next;
	end
	assign o_level = st_reg.q;
	chk_sync_agree: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ3]
		(st_reg.s2 == st_reg.s3) |=> (o_level == $past(st_reg.s3)))
		else $error("filtered level missed agreed samples");
endmodule
`default_nettype wire

// >>> rtl/bus_tstate_seq.sv
`timescale 1ns/10ps
`default_nettype none
module bus_tstate_seq import lbus_pkg::*; #(parameter int unsigned CLOCK_OUTPUT_DIV = 2) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// sequencer side of the state link
	bus_seq_if.seq sq
);
	seq_t st_reg, st_next;
	logic pend;
	assign pend = (st_reg.div == 8'(CLOCK_OUTPUT_DIV - 1));
	// every state of a bus cycle lasts one clock-output period
	always_comb begin
		st_next = st_reg;
		st_next.div = pend ? 8'h00 : st_reg.div + 8'h01;
		if (pend) begin
			unique case (st_reg.ts)
				T_IDLE: if (sq.go) st_next.ts = T_1; // [RQ21]
				T_1: begin
					st_next.ts = T_2;
					st_next.waits = sq.waits;
				end
				T_2: st_next.ts = T_3;
				T_3, T_W: begin
					// waits are counted down before T4
					if (st_reg.waits != 4'h0) begin
						st_next.ts = T_W;
						st_next.waits = st_reg.waits - 4'h1;
					end else begin
						st_next.ts = T_4; // [RQ21]
					end
				end
				T_4: st_next.ts = sq.go ? T_1 : T_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_reset) st_reg <= '{div: 8'h00, waits: 4'h0, ts: T_IDLE};
		else st_reg <= st_next;
	end
	assign sq.tstate = st_reg.ts;
	assign sq.clock_output = (st_reg.div < 8'(CLOCK_OUTPUT_DIV / 2));
	assign sq.period_end = pend;
	chk_t1_to_t2: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ21]
		(st_reg.ts == T_1 && pend) |=> (st_reg.ts == T_2))
		else $error("T1 not followed by T2");
	chk_t2_to_t3: assert property (@(posedge i_clk) disable iff (i_reset) // [RQ21]
		(st_reg.ts == T_2 && pend) |=> (st_reg.ts == T_3))
		else $error("T2 not followed by T3");
endmodule
`default_nettype wire

// >>> bench/lbus_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module lbus_mem_model (
	// clock and strobes seen from the device
	input wire logic i_clk,
	input wire logic i_ale,
	input wire logic i_wr_n,
	input wire logic i_wr_oe,
	// bus lines seen from the device
	input wire logic [3:0] i_up,
	input wire logic [7:0] i_mid,
	input wire logic [7:0] i_ad,
	input wire logic i_refresh_cycle_n_n,
	// memory answer and observations
	output logic [7:0] o_ad,
	output logic [19:0] o_addr,
	output logic [7:0] o_wdata,
	output logic [3:0] o_stat,
	output logic [7:0] o_mid2,
	output logic o_refresh_cycle_n_n,
	output logic [7:0] o_wlen
);
	logic ale_d = 1'b0;
	logic t2 = 1'b0;
	logic wr_lo = 1'b0;
	logic [7:0] n = 8'h00;
	initial o_ad = 8'h00;
	// latch, memory and watcher; junk on the lines until a new address is latched
	always @(posedge i_clk) begin
		ale_d <= i_ale;
		t2 <= ale_d && !i_ale;
		wr_lo <= i_wr_oe && !i_wr_n;
		if (!ale_d && i_ale)
			o_ad <= ~o_ad;
		if (ale_d && !i_ale) begin
			o_addr <= {i_up, i_mid, i_ad};
			o_ad <= i_ad ^ 8'h5a;
		end
		if (t2) begin
			o_stat <= i_up;
			o_mid2 <= i_mid;
			o_refresh_cycle_n_n <= i_refresh_cycle_n_n;
		end
		if (i_wr_oe && !i_wr_n)
			n <= n + 8'h01;
		if (wr_lo && !(i_wr_oe && !i_wr_n)) begin
			o_wlen <= n;
			o_wdata <= i_ad;
			n <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// >>> bench/local_bus_pin_signalling_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "lbus_defines.svh"
module local_bus_pin_signalling_bench;
	import lbus_pkg::*;
	localparam int DIV = 2;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [4:0] i_avs_address = 5'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic i_instr_boundary = 1'b0;
	logic i_bus_hold = 1'b0;
	logic i_nmi_pin = 1'b0;
	logic i_irq_in_a = 1'b0;
	logic i_irq_in_b_or_slave_sel = 1'b0;
	logic irq_c = 1'b0;
	logic irq_d = 1'b0;
	logic i_test_pin = 1'b1;
	logic i_read_strobe_or_queue_mode_sel = 1'b1;
	logic [31:0] o_avs_readdata, rv;
	logic o_avs_waitrequest, o_nmi_start, o_clock_output, m_refresh_cycle_n;
	logic [7:0] o_int_type, o_mid_addr_line, o_muxed_addr_data_line, mem_ad, m_wdata, m_mid, m_wlen;
	logic [3:0] o_upper_addr_status, m_stat;
	logic [19:0] m_addr;
	logic o_irq_in_c_or_ack_out_a, o_irq_in_c_or_ack_out_a_oe, o_irq_in_d_or_ack_out_b;
	logic o_irq_in_d_or_ack_out_b_oe, o_upper_addr_status_oe, o_mid_addr_line_oe;
	logic o_muxed_addr_data_line_oe, o_refresh_cycle_n, o_refresh_cycle_n_oe;
	logic o_addr_strobe_or_queue_stat0, o_write_strobe_or_queue_stat1;
	logic o_write_strobe_or_queue_stat1_oe;
	logic [1:0] ack_seen = 2'b00;
	logic [1:0] qs_seen = 2'b00;
	logic enh = 1'b1;
	int num_errors = 0, samples_checked = 0, cyc = 0, nmi_cnt = 0;
	wire logic [7:0] i_muxed_addr_data_line;
	wire logic i_irq_in_c_or_ack_out_a, i_irq_in_d_or_ack_out_b;
	// two-way pins resolve from whoever drives them
	assign i_muxed_addr_data_line = o_muxed_addr_data_line_oe ? o_muxed_addr_data_line
		: mem_ad;
	assign i_irq_in_c_or_ack_out_a = o_irq_in_c_or_ack_out_a_oe ? o_irq_in_c_or_ack_out_a : irq_c;
	assign i_irq_in_d_or_ack_out_b = o_irq_in_d_or_ack_out_b_oe ? o_irq_in_d_or_ack_out_b : irq_d;
	lbus_pins #(.CLOCK_OUTPUT_DIV(DIV)) DUT (.i_clk, .i_reset, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .i_instr_boundary,
		.i_bus_hold, .o_nmi_start, .o_int_type, .i_nmi_pin, .i_irq_in_a, .i_irq_in_b_or_slave_sel,
		.i_irq_in_c_or_ack_out_a, .o_irq_in_c_or_ack_out_a, .o_irq_in_c_or_ack_out_a_oe,
		.i_irq_in_d_or_ack_out_b, .o_irq_in_d_or_ack_out_b, .o_irq_in_d_or_ack_out_b_oe,
		.i_test_pin, .i_read_strobe_or_queue_mode_sel, .o_clock_output, .o_upper_addr_status,
		.o_upper_addr_status_oe, .o_mid_addr_line, .o_mid_addr_line_oe, .i_muxed_addr_data_line,
		.o_muxed_addr_data_line, .o_muxed_addr_data_line_oe, .o_refresh_cycle_n,
		.o_refresh_cycle_n_oe, .o_addr_strobe_or_queue_stat0, .o_write_strobe_or_queue_stat1,
		.o_write_strobe_or_queue_stat1_oe);
	lbus_mem_model mem (.i_clk, .i_ale(o_addr_strobe_or_queue_stat0),
		.i_wr_n(o_write_strobe_or_queue_stat1), .i_wr_oe(o_write_strobe_or_queue_stat1_oe),
		.i_up(o_upper_addr_status), .i_mid(o_mid_addr_line), .i_ad(i_muxed_addr_data_line),
		.i_refresh_cycle_n_n(o_refresh_cycle_n), .o_ad(mem_ad), .o_addr(m_addr), .o_wdata(m_wdata),
		.o_stat(m_stat), .o_mid2(m_mid), .o_refresh_cycle_n_n(m_refresh_cycle_n), .o_wlen(m_wlen));
	always #2.5 i_clk = ~i_clk;
	// watchers of short pulses, plus the hang limit (whole run is about a thousand cycles)
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_nmi_start === 1'b1)
			nmi_cnt <= nmi_cnt + 1;
		if (o_irq_in_c_or_ack_out_a_oe && o_irq_in_c_or_ack_out_a === 1'b0)
			ack_seen[0] <= 1'b1;
		if (o_irq_in_d_or_ack_out_b_oe && o_irq_in_d_or_ack_out_b === 1'b0)
			ack_seen[1] <= 1'b1;
		if ({o_write_strobe_or_queue_stat1, o_addr_strobe_or_queue_stat0} != 2'b00)
			qs_seen <= {o_write_strobe_or_queue_stat1, o_addr_strobe_or_queue_stat0};
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	function automatic logic [4:0] oes();
		return {o_upper_addr_status_oe, o_mid_addr_line_oe, o_muxed_addr_data_line_oe,
			o_refresh_cycle_n_oe, o_write_strobe_or_queue_stat1_oe};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// one avalon transfer; the request stands until waitrequest is seen low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		rv = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (n >= 50)
			num_errors++;
		tick(1);
	endtask
	task automatic do_reset(input logic tdrop, input logic rds);
		int ck;
		ck = 0;
		i_reset <= 1'b1;
		i_test_pin <= 1'b1;
		i_read_strobe_or_queue_mode_sel <= rds;
		tick(2);
		check(oes(), 0);
		i_reset <= 1'b0;
		tick(4);
		i_test_pin <= !tdrop;
		tick(20);
		av(0, `OFS_STAT, 0);
		check(rv[8], 1'b1);
		check(rv[2:1], {!rds, tdrop});
		enh = tdrop;
		// clock output is high for half of every period
		repeat (2 * DIV) begin
			@(posedge i_clk);
			ck += int'(o_clock_output);
		end
		check(ck, DIV);
	endtask
	// one bus cycle, then everything the latch and memory saw is compared
	task automatic bus_cycle(input logic w, input logic [19:0] a, input logic [7:0] d,
		input logic dma, input logic rf, input logic [3:0] ws);
		int n;
		n = 0;
		av(1, `OFS_ADDR, {12'h0, a});
		av(1, `OFS_DATA, {24'h0, d});
		av(1, `OFS_CMD, {24'h0, ws, 1'b0, rf, dma, w});
		do begin
			av(0, `OFS_STAT, 0);
			n++;
		end while ((rv[0] !== 1'b0 || m_addr !== a) && n < 40);
		check(m_addr, a);
		check(m_mid, a[15:8]);
		check(m_stat, {dma | rf, 3'b000});
		check(m_refresh_cycle_n, !(enh && rf));
		if (w) begin
			check(m_wdata, d);
			check(m_wlen, (2 + ws) * DIV);
		end else begin
			av(0, `OFS_DATA, 0);
			check(rv[7:0], a[7:0] ^ 8'h5a);
		end
	endtask
	task automatic run_bus(input int cnt);
		for (int i = 0; i < cnt; i++)
			bus_cycle(1'($urandom), 20'($urandom), 8'($urandom), 1'($urandom), 1'($urandom),
				4'($urandom_range(0, 3)));
	endtask
	initial begin
		void'($urandom(19596));
		@(posedge i_clk);
		do_reset(1'b1, 1'b1);
		bus_cycle(1'b1, 20'hfffff, 8'ha5, 1'b0, 1'b0, 4'hf);
		bus_cycle(1'b0, 20'h00000, 8'h00, 1'b1, 1'b1, 4'h0);
		run_bus(16);
		$display("test bus_cycles done");
		// bus granted away while idle: every bus pin but the clock output and the address strobe lets go
		i_bus_hold <= 1'b1;
		tick(2);
		check(oes(), 0);
		i_bus_hold <= 1'b0;
		tick(2);
		$display("test hold done");
		// nmi pulse is one clock-output period long; taken only at a boundary
		i_nmi_pin <= 1'b1;
		tick(DIV);
		i_nmi_pin <= 1'b0;
		tick(8);
		check(nmi_cnt, 0);
		i_instr_boundary <= 1'b1;
		tick(8);
		i_instr_boundary <= 1'b0;
		check(nmi_cnt, 1);
		check(o_int_type, 8'h02);
		$display("test nmi done");
		// request a is level, b is edge; both held until acknowledged
		av(1, `OFS_CTRL, 32'h1);
		i_irq_in_a <= 1'b1;
		i_irq_in_b_or_slave_sel <= 1'b1;
		tick(8);
		av(0, `OFS_STAT, 0);
		check(rv[5:4], 2'b11);
		av(1, `OFS_ACK, 32'h3);
		av(0, `OFS_STAT, 0);
		check(rv[5:4], 2'b01);
		i_irq_in_a <= 1'b0;
		i_irq_in_b_or_slave_sel <= 1'b0;
		tick(8);
		av(0, `OFS_STAT, 0);
		check(rv[5:4], 2'b00);
		av(1, `OFS_CTRL, 32'h30);
		check({o_irq_in_c_or_ack_out_a_oe, o_irq_in_d_or_ack_out_b_oe}, 2'b11);
		check(ack_seen, 2'b00);
		av(1, `OFS_ACK, 32'hc);
		tick(6);
		check(ack_seen, 2'b11);
		$display("test interrupts done");
		do_reset(1'b0, 1'b1);
		bus_cycle(1'b1, 20'h5a5a5, 8'h3c, 1'b0, 1'b1, 4'h1);
		run_bus(4);
		$display("test compatible done");
		// queue status mode: codes 01, 11 and 10 must each show on the two strobe pins
		do_reset(1'b0, 1'b0);
		for (int k = 0; k < 3; k++) begin
			logic [1:0] q;
			q = (k == 0) ? 2'h1 : (k == 1) ? 2'h3 : 2'h2;
			av(1, `OFS_QSTAT, {30'h0, q});
			tick(4);
			check(qs_seen, q);
		end
		$display("test queue_status done");
		give_verdict();
	end
endmodule
`default_nettype wire
